// file: logic/ihs_host.sv
// Purpose: I2C host sequencer: start, restart, transmit, receive, acknowledge, stop.
// Assumes: Pins are open drain; an enable high pulls the line low.
// Notes: Registers sit behind an Avalon-MM slave answering one cycle after a request.
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ihs_host (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic sleep_mode,
    output logic wake
);
    typedef struct packed {
        ihs_pkg::ihs_state_e st;
        logic hi;
        logic [2:0] bits;
        logic [7:0] shreg;
        logic [7:0] dbuf;
        logic [7:0] baud;
        logic [8:0] ctrl;
        logic bf, write_collision_flag, irq, bcol, ovf, sseen, pseen, lost;
        logic scl_oe, sda_oe;
        logic [1:0] scl_sy, sda_sy, slp_sy;
        logic scl_p, sda_p;
        logic wreq;
        logic [31:0] rdata;
        logic wake;
    } ihs_host_s;
    ihs_host_s q, n;
    logic exp, ld, coll, acc_wr, acc_rd, scl_s, sda_s;

    ihs_baud #(.W(8)) u_baud (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(ld),
        .halt(exp && !ld),
        .reload(q.baud),
        .expire(exp)
    );

    assign scl_s = q.scl_sy[1];
    assign sda_s = q.sda_sy[1];
    assign acc_wr = avs_write && !q.wreq;
    assign acc_rd = avs_read && !q.wreq;

    function automatic logic [31:0] stat_word(input ihs_host_s s);
        logic [31:0] w;
        w = '0;
        w[ihs_pkg::S_BF] = s.bf;
        w[ihs_pkg::S_WRITE_COLLISION_FLAG] = s.write_collision_flag;
        w[ihs_pkg::S_IRQ] = s.irq;
        w[ihs_pkg::S_BCOL] = s.bcol;
        w[ihs_pkg::S_START] = s.sseen;
        w[ihs_pkg::S_STOP] = s.pseen;
        w[ihs_pkg::S_FREE] = s.pseen || !s.sseen;
        w[ihs_pkg::S_OVF] = s.ovf;
        return w;
    endfunction

    always_comb
    begin
        n = q;
        ld = 1'b0;
        coll = 1'b0;
        n.scl_sy = {q.scl_sy[0], scl_in};
        n.sda_sy = {q.sda_sy[0], sda_in};
        n.slp_sy = {q.slp_sy[0], sleep_mode};
        n.scl_p = scl_s;
        n.sda_p = sda_s;
        // Avalon slave: one wait cycle, then the access takes effect.
        n.wreq = !((avs_read || avs_write) && q.wreq);
        if (avs_read && q.wreq)
        begin
            case (avs_address)
                ihs_pkg::ADDR_DATA: n.rdata = {24'h000000, q.dbuf};
                ihs_pkg::ADDR_CTRL: n.rdata = {23'h000000, q.ctrl};
                ihs_pkg::ADDR_STAT: n.rdata = stat_word(q);
                ihs_pkg::ADDR_BAUD: n.rdata = {24'h000000, q.baud};
                default: n.rdata = '0;
            endcase
        end
        if (acc_rd && avs_address == ihs_pkg::ADDR_DATA)
        begin
            n.bf = 1'b0;
        end
        if (acc_wr)
        begin
            case (avs_address)
                ihs_pkg::ADDR_DATA:
                begin
                    if (q.st != ihs_pkg::ST_IDLE || !q.ctrl[ihs_pkg::C_PORTEN])
                    begin
                        n.write_collision_flag = 1'b1;
                    end
                    else
                    begin
                        n.dbuf = avs_writedata[7:0];
                        n.shreg = avs_writedata[7:0];
                        n.bits = 3'h0;
                        n.bf = 1'b1;
                        n.lost = 1'b0;
                        n.scl_oe = 1'b1;
                        n.st = ihs_pkg::ST_TXL;
                        ld = 1'b1;
                    end
                end
                ihs_pkg::ADDR_CTRL:
                begin
                    n.ctrl[ihs_pkg::C_ACK_DATA_BIT] = avs_writedata[ihs_pkg::C_ACK_DATA_BIT];
                    n.ctrl[ihs_pkg::C_PORTEN] = avs_writedata[ihs_pkg::C_PORTEN];
                    n.ctrl[ihs_pkg::C_IRQEN] = avs_writedata[ihs_pkg::C_IRQEN];
                    // Sequence enables are only taken while the port is idle.
                    if (q.st == ihs_pkg::ST_IDLE && q.ctrl[4:0] == 5'h00)
                    begin
                        n.ctrl[4:0] = avs_writedata[4:0];
                    end
                end
                ihs_pkg::ADDR_STAT:
                begin
                    if (avs_writedata[ihs_pkg::S_WRITE_COLLISION_FLAG]) n.write_collision_flag = 1'b0;
                    if (avs_writedata[ihs_pkg::S_IRQ]) n.irq = 1'b0;
                    if (avs_writedata[ihs_pkg::S_BCOL]) n.bcol = 1'b0;
                    if (avs_writedata[ihs_pkg::S_OVF]) n.ovf = 1'b0;
                end
                ihs_pkg::ADDR_BAUD: n.baud = avs_writedata[7:0];
                default: ;
            endcase
        end
        // Bus monitor: while the port is enabled, seen bits follow every start and stop, ours or not.
        // It sits after the register writes so that a bus Stop wins over a flag clear.
        if (scl_s && q.scl_p && q.sda_p && !sda_s)
        begin
            n.sseen = 1'b1;
            n.pseen = 1'b0;
        end
        if (scl_s && q.scl_p && !q.sda_p && sda_s)
        begin
            n.pseen = 1'b1;
            n.sseen = 1'b0;
            if (q.st != ihs_pkg::ST_PC && q.ctrl[ihs_pkg::C_IRQEN])
            begin
                n.irq = 1'b1;
            end
        end
        case (q.st)
            ihs_pkg::ST_IDLE:
            begin
                if (q.ctrl[ihs_pkg::C_START])
                begin
                    if (!sda_s || !scl_s)
                    begin
                        coll = 1'b1;
                    end
                    else
                    begin
                        n.st = ihs_pkg::ST_S1;
                        ld = 1'b1;
                    end
                end
                else if (q.ctrl[ihs_pkg::C_RESTART])
                begin
                    n.scl_oe = 1'b1;
                    n.sda_oe = 1'b0;
                    if (!scl_s)
                    begin
                        n.st = ihs_pkg::ST_R1;
                        ld = 1'b1;
                    end
                end
                else if (q.ctrl[ihs_pkg::C_RECV])
                begin
                    n.scl_oe = 1'b1;
                    n.sda_oe = 1'b0;
                    n.bits = 3'h0;
                    n.st = ihs_pkg::ST_RXL;
                    ld = 1'b1;
                end
                else if (q.ctrl[ihs_pkg::C_ACK_SEQUENCE_ENABLE])
                begin
                    n.scl_oe = 1'b1;
                    n.sda_oe = !q.ctrl[ihs_pkg::C_ACK_DATA_BIT];
                    n.st = ihs_pkg::ST_AKL;
                    ld = 1'b1;
                end
                else if (q.ctrl[ihs_pkg::C_STOP])
                begin
                    n.scl_oe = 1'b1;
                    n.sda_oe = 1'b1;
                    n.st = ihs_pkg::ST_PA;
                end
            end
            ihs_pkg::ST_S1:
            begin
                if (!scl_s)
                begin
                    coll = 1'b1;
                end
                else if (!sda_s || exp)
                begin
                    n.sda_oe = 1'b1;
                    n.st = ihs_pkg::ST_S2;
                    ld = 1'b1;
                end
            end
            ihs_pkg::ST_S2:
            begin
                if (exp)
                begin
                    n.scl_oe = 1'b1;
                    n.ctrl[ihs_pkg::C_START] = 1'b0;
                    n.irq = 1'b1;
                    n.st = ihs_pkg::ST_IDLE;
                end
            end
            ihs_pkg::ST_R1:
            begin
                if (exp && sda_s)
                begin
                    n.scl_oe = 1'b0;
                    n.st = ihs_pkg::ST_R2;
                end
            end
            ihs_pkg::ST_R2:
            begin
                if (scl_s && !sda_s)
                begin
                    coll = 1'b1;
                end
                else if (scl_s)
                begin
                    n.st = ihs_pkg::ST_R3;
                    ld = 1'b1;
                end
            end
            ihs_pkg::ST_R3:
            begin
                if (!scl_s)
                begin
                    coll = 1'b1;
                end
                else if (exp)
                begin
                    n.sda_oe = 1'b1;
                    n.st = ihs_pkg::ST_R4;
                    ld = 1'b1;
                end
            end
            ihs_pkg::ST_R4:
            begin
                if (exp)
                begin
                    n.scl_oe = 1'b1;
                    n.ctrl[ihs_pkg::C_RESTART] = 1'b0;
                    n.irq = 1'b1;
                    n.st = ihs_pkg::ST_IDLE;
                end
            end
            ihs_pkg::ST_TXL, ihs_pkg::ST_AIL, ihs_pkg::ST_RXL, ihs_pkg::ST_AKL:
            begin
                if (q.st == ihs_pkg::ST_TXL)
                begin
                    n.sda_oe = !q.shreg[7];
                end
                if (exp)
                begin
                    n.scl_oe = 1'b0;
                    n.hi = 1'b0;
                    n.st = ihs_pkg::ihs_state_e'(q.st + 5'h01);
                end
            end
            ihs_pkg::ST_TXH, ihs_pkg::ST_AIH, ihs_pkg::ST_RXH, ihs_pkg::ST_AKH:
            begin
                if (!q.hi)
                begin
                    if (scl_s)
                    begin
                        n.hi = 1'b1;
                        ld = 1'b1;
                    end
                end
                else if (!q.sda_oe && !sda_s
                         && (q.st == ihs_pkg::ST_TXH || (q.st == ihs_pkg::ST_AKH)))
                begin
                    coll = 1'b1;
                end
                else if (exp)
                begin
                    n.scl_oe = 1'b1;
                    n.hi = 1'b0;
                    n.st = ihs_pkg::ihs_state_e'(q.st - 5'h01);
                    case (q.st)
                        ihs_pkg::ST_TXH:
                        begin
                            n.shreg = {q.shreg[6:0], 1'b0};
                            n.bits = q.bits + 3'h1;
                            if (q.bits == 3'h7)
                            begin
                                n.bf = 1'b0;
                                n.sda_oe = 1'b0;
                                n.st = ihs_pkg::ST_AIL;
                            end
                            ld = 1'b1;
                        end
                        ihs_pkg::ST_AIH:
                        begin
                            n.ctrl[ihs_pkg::C_ACK_RECEIVED_STATUS] = sda_s;
                            n.irq = 1'b1;
                            n.st = ihs_pkg::ST_IDLE;
                        end
                        ihs_pkg::ST_RXH:
                        begin
                            n.shreg = {q.shreg[6:0], sda_s};
                            n.bits = q.bits + 3'h1;
                            ld = 1'b1;
                            if (q.bits == 3'h7)
                            begin
                                n.dbuf = {q.shreg[6:0], sda_s};
                                n.ovf = q.ovf || q.bf;
                                n.bf = 1'b1;
                                n.irq = 1'b1;
                                n.ctrl[ihs_pkg::C_RECV] = 1'b0;
                                n.st = ihs_pkg::ST_IDLE;
                                ld = 1'b0;
                            end
                        end
                        default:
                        begin
                            n.ctrl[ihs_pkg::C_ACK_SEQUENCE_ENABLE] = 1'b0;
                            n.sda_oe = 1'b0;
                            n.irq = 1'b1;
                            n.st = ihs_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            ihs_pkg::ST_PA:
            begin
                if (!sda_s)
                begin
                    n.st = ihs_pkg::ST_PB;
                    ld = 1'b1;
                end
            end
            ihs_pkg::ST_PB:
            begin
                if (exp && q.scl_oe)
                begin
                    n.scl_oe = 1'b0;
                    ld = 1'b1;
                end
                else if (exp)
                begin
                    n.sda_oe = 1'b0;
                    n.st = ihs_pkg::ST_PC;
                end
            end
            ihs_pkg::ST_PC:
            begin
                if (!q.hi && sda_s && scl_s)
                begin
                    n.hi = 1'b1;
                    ld = 1'b1;
                end
                else if (q.hi && exp)
                begin
                    n.hi = 1'b0;
                    n.ctrl[ihs_pkg::C_STOP] = 1'b0;
                    n.irq = 1'b1;
                    n.st = ihs_pkg::ST_IDLE;
                end
            end
            default: n.st = ihs_pkg::ST_IDLE;
        endcase
        if (coll)
        begin
            n.bcol = 1'b1;
            n.lost = 1'b1;
            n.bf = 1'b0;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.hi = 1'b0;
            n.ctrl[4:0] = 5'h00;
            n.st = ihs_pkg::ST_IDLE;
            ld = 1'b0;
        end
        if (!q.ctrl[ihs_pkg::C_PORTEN])
        begin
            n.st = ihs_pkg::ST_IDLE;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.sseen = 1'b0;
            n.pseen = 1'b0;
            n.ctrl[4:0] = 5'h00;
            ld = 1'b0;
        end
        // Client-side wake is reduced to the set interrupt flag (S_IRQ), with the interrupt enable on, in sleep.
        n.wake = q.slp_sy[1] && q.ctrl[ihs_pkg::C_IRQEN] && q.irq;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.wreq <= 1'b1;
            q.baud <= ihs_pkg::BAUD_RST;
            q.scl_sy <= 2'h3;
            q.sda_sy <= 2'h3;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end
        else
        begin
            q <= n;
        end
    end

    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wreq;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;
    assign wake = q.wake;

    sequence s_ack_end;
        q.st == ihs_pkg::ST_AKH && q.hi && exp && !coll && q.ctrl[ihs_pkg::C_PORTEN];
    endsequence
    a_ack_finish: assert property (@(posedge clk) disable iff (sys_rst)
        s_ack_end |=> q.st == ihs_pkg::ST_IDLE && !q.ctrl[ihs_pkg::C_ACK_SEQUENCE_ENABLE] && q.scl_oe)
        else $error("ack sequence did not end cleanly");
    a_ack_drive: assert property (@(posedge clk) disable iff (sys_rst)
        q.st == ihs_pkg::ST_AKL |-> q.scl_oe && q.sda_oe == !q.ctrl[ihs_pkg::C_ACK_DATA_BIT])
        else $error("ack bit not driven");
    a_write_collision_flag_busy: assert property (@(posedge clk) disable iff (sys_rst)
        acc_wr && avs_address == ihs_pkg::ADDR_DATA && q.st != ihs_pkg::ST_IDLE
        |=> q.write_collision_flag && q.dbuf == $past(q.dbuf))
        else $error("busy buffer write not refused");
    a_rx_byte: assert property (@(posedge clk) disable iff (sys_rst)
        q.st == ihs_pkg::ST_RXH && q.hi && exp && q.bits == 3'h7 && !coll
        && q.ctrl[ihs_pkg::C_PORTEN] |=> q.bf && q.irq && !q.ctrl[ihs_pkg::C_RECV])
        else $error("received byte not flagged");
    a_read_bf: assert property (@(posedge clk) disable iff (sys_rst)
        acc_rd && avs_address == ihs_pkg::ADDR_DATA && q.st != ihs_pkg::ST_RXH
        |=> !q.bf)
        else $error("buffer read did not clear full");
    a_start_busy: assert property (@(posedge clk) disable iff (sys_rst)
        q.st == ihs_pkg::ST_IDLE && q.ctrl[ihs_pkg::C_START] && q.ctrl[ihs_pkg::C_PORTEN]
        && (!sda_s || !scl_s) |=> q.bcol && !q.ctrl[ihs_pkg::C_START])
        else $error("start on busy bus not aborted");
    a_coll_release: assert property (@(posedge clk) disable iff (sys_rst)
        coll |=> !q.scl_oe && !q.sda_oe && !q.bf && q.st == ihs_pkg::ST_IDLE)
        else $error("collision did not release the bus");
    a_stop_done: assert property (@(posedge clk) disable iff (sys_rst)
        q.st == ihs_pkg::ST_PC && q.hi && exp && q.ctrl[ihs_pkg::C_PORTEN]
        |=> q.irq && !q.ctrl[ihs_pkg::C_STOP] && !q.sda_oe && !q.scl_oe)
        else $error("stop did not complete");
endmodule // ihs_host
`default_nettype wire

// file: common/ihs_pkg.sv
// Purpose: Shared constants for the I2C host sequencer.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes: Baud reload is 8 bits wide; one baud period is reload plus one cycles.
package ihs_pkg;
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [3:0] ADDR_BAUD = 4'hC;
    // Control register bits.
    localparam int C_START = 0;
    localparam int C_RESTART = 1;
    localparam int C_STOP = 2;
    localparam int C_RECV = 3;
    localparam int C_ACK_SEQUENCE_ENABLE = 4;
    localparam int C_ACK_DATA_BIT = 5;
    localparam int C_ACK_RECEIVED_STATUS = 6;
    localparam int C_PORTEN = 7;
    localparam int C_IRQEN = 8;
    // Status register bits; write-one clears S_WRITE_COLLISION_FLAG, S_IRQ, S_BCOL and S_OVF.
    localparam int S_BF = 0;
    localparam int S_WRITE_COLLISION_FLAG = 1;
    localparam int S_IRQ = 2;
    localparam int S_BCOL = 3;
    localparam int S_START = 4;
    localparam int S_STOP = 5;
    localparam int S_FREE = 6;
    localparam int S_OVF = 7;
    localparam logic [7:0] BAUD_RST = 8'h09;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h00, ST_S1 = 5'h01, ST_S2 = 5'h02, ST_TXL = 5'h03, ST_TXH = 5'h04,
        ST_AIL = 5'h05, ST_AIH = 5'h06, ST_RXL = 5'h07, ST_RXH = 5'h08, ST_AKL = 5'h09,
        ST_AKH = 5'h0A, ST_PA = 5'h0B, ST_PB = 5'h0C, ST_PC = 5'h0D, ST_R1 = 5'h0E,
        ST_R2 = 5'h0F, ST_R3 = 5'h10, ST_R4 = 5'h11
    } ihs_state_e;
endpackage

// file: logic/ihs_baud.sv
// Purpose: Down-counting baud generator defining one baud period.
// Assumes: The owner loads or halts it on every expiry.
// Notes: A period lasts reload plus one clock cycles.
`timescale 1ns/1ps
`default_nettype none
module ihs_baud #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic halt,
    input wire logic [W-1:0] reload,
    output logic expire
);
    typedef struct packed {
        logic run;
        logic [W-1:0] cnt;
    } ihs_baud_s;
    ihs_baud_s q, n;

    always_comb
    begin
        n = q;
        if (load)
        begin
            n.run = 1'b1;
            n.cnt = reload;
        end
        else if (halt)
        begin
            n.run = 1'b0;
        end
        else if (q.run && q.cnt != '0)
        begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign expire = q.run && (q.cnt == '0);
endmodule // ihs_baud
`default_nettype wire

// file: test/ihs_client.sv
// Purpose: Behavioural I2C client that acknowledges an address and sends a fixed byte on reads.
// Assumes: Open-drain lines with pull-ups; the host makes every clock pulse.
// Notes: Data moves 100 ns after a clock fall so that it never changes while the clock is high.
`timescale 1ns/1ps
`default_nettype none
module ihs_client #(
    parameter logic [7:0] RD_BYTE = 8'hA5
) (
    input wire logic scl,
    input wire logic sda,
    output logic pull
);
    int k = 0;
    logic first = 1'b1;
    logic rd = 1'b0;
    initial pull = 1'b0;
    always @(negedge sda)
    begin
        if (scl)
        begin
            k = 0;
            first = 1'b1;
        end
    end
    always @(posedge scl)
    begin
        if (k == 8 && first)
            rd = sda;
    end
    always @(negedge scl)
    begin
        if (k == 9)
            first = 1'b0;
        k = (k == 9) ? 1 : k + 1;
        pull <= #100 (k == 9 && (first || !rd)) || (!first && rd && k < 9 && !RD_BYTE[8 - k]);
    end
endmodule // ihs_client
`default_nettype wire

// file: test/ihs_host_bench.sv
// Purpose: Register-level bench for the I2C host sequencer against a client model.
// Assumes: Baud reload 4 gives a five-cycle baud period.
// Notes: Flags are polled over the register bus, since the block has no interrupt line.
`timescale 1ns/1ps
`default_nettype none
module ihs_host_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] q;
    logic avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe, wake, pull;
    logic sleep_mode = 1'b0;
    logic jam = 1'b0;
    int n_mismatch = 0;
    int n_compared = 0;
    wire scl = !scl_oe;
    wire sda = !(sda_oe || pull || jam);
    ihs_host i_ihs_host (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .sleep_mode(sleep_mode), .wake(wake));
    ihs_client i_ihs_client (.scl(scl), .sda(sda), .pull(pull));
    initial
        forever #25 clk = ~clk;
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // The request is held until the edge that samples waitrequest low.
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        check(q & m, e);
    endtask
    task automatic wait_st(input int b);
        int n;
        for (n = 0; n < 300; n++)
        begin
            bus(ihs_pkg::ADDR_STAT, 1'b0, 32'h0);
            if (q[b] === 1'b1)
                return;
        end
        n_mismatch++;
        print_verdict();
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(ihs_pkg::ADDR_CTRL, 32'h1FF, 32'h0);
        rdc(ihs_pkg::ADDR_BAUD, 32'hFF, 32'h09);
        rdc(ihs_pkg::ADDR_STAT, 32'hFF, 32'h40);
        rdc(4'h1, 32'hFFFFFFFF, 32'h0);
        check({30'h0, scl_out, sda_out}, 32'h0);
        bus(ihs_pkg::ADDR_BAUD, 1'b1, 32'h04);
        // A sequence bit written together with the enable is dropped, so enable first.
        bus(ihs_pkg::ADDR_CTRL, 1'b1, 32'h180);
        bus(ihs_pkg::ADDR_CTRL, 1'b1, 32'h181);
        wait_st(ihs_pkg::S_IRQ);
        rdc(ihs_pkg::ADDR_STAT, 32'h18, 32'h10);
        bus(ihs_pkg::ADDR_STAT, 1'b1, 32'h4);
        bus(ihs_pkg::ADDR_DATA, 1'b1, 32'hA1);
        wait_st(ihs_pkg::S_IRQ);
        rdc(ihs_pkg::ADDR_STAT, 32'h8, 32'h0);
        bus(ihs_pkg::ADDR_STAT, 1'b1, 32'h4);
        bus(ihs_pkg::ADDR_CTRL, 1'b1, 32'h188);
        wait_st(ihs_pkg::S_IRQ);
        sleep_mode <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, wake}, 32'h1);
        sleep_mode <= 1'b0;
        rdc(ihs_pkg::ADDR_STAT, 32'h1, 32'h1);
        rdc(ihs_pkg::ADDR_DATA, 32'hFF, 32'hA5);
        rdc(ihs_pkg::ADDR_STAT, 32'h1, 32'h0);
        bus(ihs_pkg::ADDR_STAT, 1'b1, 32'h4);
        bus(ihs_pkg::ADDR_CTRL, 1'b1, 32'h1B0);
        bus(ihs_pkg::ADDR_DATA, 1'b1, 32'h3C);
        wait_st(ihs_pkg::S_IRQ);
        rdc(ihs_pkg::ADDR_STAT, 32'h2, 32'h2);
        rdc(ihs_pkg::ADDR_CTRL, 32'h10, 32'h0);
        rdc(ihs_pkg::ADDR_DATA, 32'hFF, 32'hA5);
        bus(ihs_pkg::ADDR_STAT, 1'b1, 32'h6);
        bus(ihs_pkg::ADDR_CTRL, 1'b1, 32'h184);
        bus(ihs_pkg::ADDR_DATA, 1'b1, 32'h3C);
        wait_st(ihs_pkg::S_IRQ);
        rdc(ihs_pkg::ADDR_STAT, 32'h62, 32'h62);
        rdc(ihs_pkg::ADDR_CTRL, 32'h4, 32'h0);
        check({30'h0, scl, sda}, 32'h3);
        bus(ihs_pkg::ADDR_STAT, 1'b1, 32'h6);
        jam <= 1'b1;
        repeat (4) @(posedge clk);
        bus(ihs_pkg::ADDR_CTRL, 1'b1, 32'h181);
        wait_st(ihs_pkg::S_BCOL);
        rdc(ihs_pkg::ADDR_CTRL, 32'h1, 32'h0);
        check({30'h0, scl_oe, sda_oe}, 32'h0);
        jam <= 1'b0;
        repeat (8) @(posedge clk);
        rdc(ihs_pkg::ADDR_STAT, 32'h24, 32'h24);
        bus(ihs_pkg::ADDR_STAT, 1'b1, 32'hE);
        bus(ihs_pkg::ADDR_CTRL, 1'b1, 32'h181);
        wait_st(ihs_pkg::S_IRQ);
        bus(ihs_pkg::ADDR_STAT, 1'b1, 32'h4);
        // A competing host holds data low under a transmitted one.
        bus(ihs_pkg::ADDR_DATA, 1'b1, 32'hFF);
        jam <= 1'b1;
        wait_st(ihs_pkg::S_BCOL);
        rdc(ihs_pkg::ADDR_STAT, 32'h9, 32'h8);
        check({30'h0, scl_oe, sda_oe}, 32'h0);
        jam <= 1'b0;
        bus(ihs_pkg::ADDR_STAT, 1'b1, 32'hE);
        bus(ihs_pkg::ADDR_DATA, 1'b1, 32'h3C);
        rdc(ihs_pkg::ADDR_STAT, 32'h3, 32'h1);
        check({31'h0, sda_oe}, 32'h1);
        bus(ihs_pkg::ADDR_CTRL, 1'b1, 32'h0);
        rdc(ihs_pkg::ADDR_STAT, 32'h30, 32'h0);
        check({30'h0, scl_oe, sda_oe}, 32'h0);
        print_verdict();
    end
endmodule // ihs_host_bench
`default_nettype wire
